// *** logic/sssrs_top.sv ***
// Supply supervisor reset sequencer, top level
`timescale 1ns/100ps
module sssrs_top
  import sssrs_pkg::*;
#(
  parameter logic        RESET_ACTIVE_LOW = 1'b1,
  parameter int unsigned TIMEOUT_CYCLES   = TIMEOUT_CYC
) (
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  input  wire logic supply_low_in,
  input  wire logic operator_reset_in_n,
  input  wire logic supply_warn_sense_in,
  input  wire logic supply_early_low_in,
  output logic      cpu_reset_out,
  output logic      supply_warn_flag_out,
  output logic      early_dropout_flag_out
);
  logic             supply_low_s;
  logic             opr_n_s;
  logic             warn_low_s;
  logic             early_low_s;
  logic             opr_active;
  sssrs_state_t     state_reg;
  sssrs_state_t     state_next;
  logic [CNT_W-1:0] tmr_reg;
  logic [CNT_W-1:0] tmr_next;
  logic             rst_reg;
  logic             rst_next;
  logic             warn_reg;
  logic             warn_next;
  logic             early_reg;
  logic             early_next;
  logic             force_rst;

  localparam logic [CNT_W-1:0] TMO_LAST = CNT_W'(TIMEOUT_CYCLES - 1);
  // Reset level for asserted and released, per variant
  localparam logic RST_ON  = ~RESET_ACTIVE_LOW;
  localparam logic RST_OFF = RESET_ACTIVE_LOW;

  initial begin
    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << CNT_W))
      $error("sssrs_top: TIMEOUT_CYCLES out of range");
  end

  // Comparator decisions arrive asynchronously
  sssrs_sync #(.RESET_VAL(1'b1)) u_sync_supply (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .async_in   (supply_low_in),
    .sync_out   (supply_low_s)
  );

  sssrs_sync #(.RESET_VAL(1'b1)) u_sync_opr (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .async_in   (operator_reset_in_n),
    .sync_out   (opr_n_s)
  );

  sssrs_sync #(.RESET_VAL(1'b0)) u_sync_warn (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .async_in   (supply_warn_sense_in),
    .sync_out   (warn_low_s)
  );

  sssrs_sync #(.RESET_VAL(1'b1)) u_sync_early (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .async_in   (supply_early_low_in),
    .sync_out   (early_low_s)
  );

  sssrs_debounce u_debounce (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .low_in     (~opr_n_s),
    .active_out (opr_active)
  );

  // Either source forces reset and restarts the timeout
  assign force_rst = supply_low_s | opr_active;

  always_comb begin
    state_next = state_reg;
    tmr_next   = tmr_reg;
    case (state_reg)
      SSSRS_HELD: begin
        tmr_next = CNT_ZERO;
        if (!force_rst) begin
          state_next = SSSRS_TIMING;
        end
      end
      SSSRS_TIMING: begin
        if (force_rst) begin
          // A dip cancels the running count
          state_next = SSSRS_HELD;
          tmr_next   = CNT_ZERO;
        end else if (tmr_reg >= TMO_LAST) begin
          state_next = SSSRS_RUN;
        end else begin
          tmr_next = tmr_reg + CNT_ONE;
        end
      end
      SSSRS_RUN: begin
        if (force_rst) begin
          state_next = SSSRS_HELD;
          tmr_next   = CNT_ZERO;
        end
      end
      default: begin
        state_next = SSSRS_HELD;
        tmr_next   = CNT_ZERO;
      end
    endcase
    // Asserted if any source is active or the timer still runs
    rst_next = (force_rst || state_next != SSSRS_RUN) ? RST_ON
                                                     : RST_OFF;
  end

  // Flag path kept apart from the reset sequencing
  always_comb begin
    warn_next  = ~warn_low_s;
    // Hysteresis lives in the comparator; this only mirrors its decision
    early_next = ~early_low_s;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= SSSRS_HELD;
      tmr_reg   <= CNT_ZERO;
      rst_reg   <= RST_ON;
    end else begin
      state_reg <= state_next;
      tmr_reg   <= tmr_next;
      rst_reg   <= rst_next;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      warn_reg  <= 1'b1;
      early_reg <= 1'b0;
    end else begin
      warn_reg  <= warn_next;
      early_reg <= early_next;
    end
  end

  assign cpu_reset_out          = rst_reg;
  assign supply_warn_flag_out   = warn_reg;
  assign early_dropout_flag_out = early_reg;
endmodule : sssrs_top

// *** logic/sssrs_pkg.sv ***
// Shared constants for the supply supervisor reset sequencer
package sssrs_pkg;
  localparam int unsigned CLK_FREQ_HZ      = 50_000_000;
  // Operator reset must stay low longer than this before it counts
  localparam int unsigned OPR_MIN_LOW_US   = 25;
  // Further delay from a recognised operator reset to reset assertion
  localparam int unsigned OPR_ASSERT_US    = 12;
  // Reset timeout default, factory set; chosen value
  localparam int unsigned TIMEOUT_US       = 200;
  localparam int unsigned OPR_MIN_LOW_CYC  =
    (OPR_MIN_LOW_US * (CLK_FREQ_HZ / 1_000_000)) + 1;
  localparam int unsigned OPR_ASSERT_CYC   =
    OPR_ASSERT_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned TIMEOUT_CYC      =
    TIMEOUT_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned CNT_W            = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE     = 24'h000001;
  typedef enum logic [1:0] {
    SSSRS_HELD    = 2'b00,
    SSSRS_TIMING  = 2'b01,
    SSSRS_RUN     = 2'b11
  } sssrs_state_t;
endpackage : sssrs_pkg

// *** logic/sssrs_sync.sv ***
// Two-stage synchroniser for an asynchronous level
`timescale 1ns/100ps
module sssrs_sync
  import sssrs_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1_reg;
  logic stage2_reg;
  logic stage1_next;
  logic stage2_next;

  always_comb begin
    stage1_next = async_in;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign sync_out = stage2_reg;
endmodule : sssrs_sync

// *** logic/sssrs_debounce.sv ***
// Operator reset debouncer: long-low recognition plus assertion delay
`timescale 1ns/100ps
module sssrs_debounce
  import sssrs_pkg::*;
#(
  parameter int unsigned MIN_LOW_CYC = OPR_MIN_LOW_CYC,
  parameter int unsigned ASSERT_CYC  = OPR_ASSERT_CYC
) (
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  input  wire logic low_in,
  output logic      active_out
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             armed_reg;
  logic             armed_next;
  logic             active_reg;
  logic             active_next;
  localparam logic [CNT_W-1:0] LOW_LAST = CNT_W'(MIN_LOW_CYC - 1);
  localparam logic [CNT_W-1:0] DLY_LAST = CNT_W'(ASSERT_CYC - 1);

  initial begin
    if (MIN_LOW_CYC < 1 || ASSERT_CYC < 1 ||
        MIN_LOW_CYC >= (1 << CNT_W) || ASSERT_CYC >= (1 << CNT_W))
      $error("sssrs_debounce: counts out of range");
  end

  always_comb begin
    cnt_next    = cnt_reg;
    armed_next  = armed_reg;
    active_next = active_reg;
    if (active_reg) begin
      if (!low_in) begin
        // Release is immediate; the timeout downstream does the rest
        active_next = 1'b0;
        armed_next  = 1'b0;
        cnt_next    = CNT_ZERO;
      end
    end else if (armed_reg) begin
      // A recognised press completes its delay even if released early
      if (cnt_reg >= DLY_LAST) begin
        active_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + CNT_ONE;
      end
    end else if (!low_in) begin
      cnt_next = CNT_ZERO;
    end else if (cnt_reg >= LOW_LAST) begin
      armed_next = 1'b1;
      cnt_next   = CNT_ZERO;
    end else begin
      cnt_next = cnt_reg + CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_reg    <= CNT_ZERO;
      armed_reg  <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      cnt_reg    <= cnt_next;
      armed_reg  <= armed_next;
      active_reg <= active_next;
    end
  end

  assign active_out = active_reg;
endmodule : sssrs_debounce

// *** tb/sssrs_monitor.sv ***
// Checker for reset sequencing and supervisor flags
`timescale 1ns/100ps
module sssrs_monitor
  import sssrs_pkg::*;
#(
  parameter logic        RESET_ACTIVE_LOW = 1'b1,
  parameter int unsigned TIMEOUT_CYCLES   = 20
) (
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  input  wire logic supply_low_in,
  input  wire logic operator_reset_in_n,
  input  wire logic supply_warn_sense_in,
  input  wire logic supply_early_low_in,
  input  wire logic cpu_reset_out,
  input  wire logic supply_warn_flag_out,
  input  wire logic early_dropout_flag_out
);
  wire logic on_w = cpu_reset_out ^ RESET_ACTIVE_LOW;
  int        good_cnt;
  int        low_cnt;
  int        press_cnt;
  // A recognised press runs its delay to the end, released or not
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      good_cnt  <= 0;
      low_cnt   <= 0;
      press_cnt <= 0;
    end else begin
      good_cnt <= (supply_low_in || press_cnt != 0) ? 0 : good_cnt + 1;
      low_cnt  <= operator_reset_in_n ? 0 : low_cnt + 1;
      if (press_cnt == 0)
        press_cnt <= (low_cnt >= OPR_MIN_LOW_CYC) ? 1 : 0;
      else
        press_cnt <= (press_cnt <= OPR_ASSERT_CYC || !operator_reset_in_n)
                     ? press_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  property p_sup; supply_low_in [*5] |-> on_w; endproperty
  a_sup: assert property (p_sup) else $error("no reset on low supply");
  property p_rel;
    $changed(cpu_reset_out) && !on_w |-> good_cnt >= TIMEOUT_CYCLES;
  endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_tmo; good_cnt >= TIMEOUT_CYCLES + 8 |-> !on_w; endproperty
  a_tmo: assert property (p_tmo) else $error("late release");
  property p_opr;
    low_cnt >= OPR_MIN_LOW_CYC + OPR_ASSERT_CYC + 6 |-> on_w;
  endproperty
  a_opr: assert property (p_opr) else $error("no operator reset");
  property p_dly; press_cnt == OPR_ASSERT_CYC + 1 |-> ##[1:8] on_w;
  endproperty
  a_dly: assert property (p_dly) else $error("no delayed reset");
  property p_wlo; supply_warn_sense_in [*5] |-> !supply_warn_flag_out;
  endproperty
  a_wlo: assert property (p_wlo) else $error("warn flag high");
  property p_whi; !supply_warn_sense_in [*5] |-> supply_warn_flag_out;
  endproperty
  a_whi: assert property (p_whi) else $error("warn flag low");
  property p_elo; supply_early_low_in [*5] |-> !early_dropout_flag_out;
  endproperty
  a_elo: assert property (p_elo) else $error("early flag high");
  property p_ehi; !supply_early_low_in [*5] |-> early_dropout_flag_out;
  endproperty
  a_ehi: assert property (p_ehi) else $error("early flag low");
endmodule : sssrs_monitor
bind sssrs_top sssrs_monitor #(
  .RESET_ACTIVE_LOW(RESET_ACTIVE_LOW), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) sssrs_monitor_inst (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
  .supply_low_in(supply_low_in), .operator_reset_in_n(operator_reset_in_n),
  .supply_warn_sense_in(supply_warn_sense_in),
  .supply_early_low_in(supply_early_low_in), .cpu_reset_out(cpu_reset_out),
  .supply_warn_flag_out(supply_warn_flag_out),
  .early_dropout_flag_out(early_dropout_flag_out));

// *** tb/sssrs_cpu_model.sv ***
// Processor side model: reset input and interrupt request counter
`timescale 1ns/100ps
module sssrs_cpu_model (
  input  wire logic clk_sys_in,
  input  wire logic cpu_reset_n_in,
  input  wire logic nmi_n_in,
  output int        nmi_cnt_out
);
  logic nmi_last;
  initial nmi_cnt_out = 0;
  always @(posedge clk_sys_in) begin
    nmi_last <= nmi_n_in;
    if (cpu_reset_n_in && nmi_last && !nmi_n_in)
      nmi_cnt_out <= nmi_cnt_out + 1;
  end
endmodule : sssrs_cpu_model

// *** tb/test_supply_supervisor_reset_sequencer.sv ***
// Self-checking bench for the supply supervisor reset sequencer
`timescale 1ns/100ps
module test_supply_supervisor_reset_sequencer;
  import sssrs_pkg::*;
  localparam int T = 20;
  logic clk_sys_in = 1'b0, reset_n_in = 1'b0, sup_low = 1'b0, opr_n = 1'b1;
  logic warn = 1'b0, early = 1'b0, nx;
  logic rst_lo, rst_hi, warn_flag, early_flag;
  int   error_cnt = 0, comparisons = 0, cycles = 0, seed = 1219, falls = 0;
  int   nmi_cnt, good_run = 0, low_run = 0, press = 0;
  sssrs_top #(.RESET_ACTIVE_LOW(1'b1), .TIMEOUT_CYCLES(T)) sssrs_top_inst (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .supply_low_in(sup_low),
    .operator_reset_in_n(opr_n), .supply_warn_sense_in(warn),
    .supply_early_low_in(early), .cpu_reset_out(rst_lo),
    .supply_warn_flag_out(warn_flag), .early_dropout_flag_out(early_flag));
  sssrs_top #(.RESET_ACTIVE_LOW(1'b0), .TIMEOUT_CYCLES(T)) sssrs_top_hi_inst (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .supply_low_in(sup_low),
    .operator_reset_in_n(opr_n), .supply_warn_sense_in(warn),
    .supply_early_low_in(early), .cpu_reset_out(rst_hi),
    .supply_warn_flag_out(), .early_dropout_flag_out());
  sssrs_cpu_model sssrs_cpu_model_inst (.clk_sys_in(clk_sys_in),
    .cpu_reset_n_in(rst_lo), .nmi_n_in(early_flag), .nmi_cnt_out(nmi_cnt));
  initial forever #10 clk_sys_in = ~clk_sys_in;
  // Reference model: debounced operator reset and timeout run length
  always @(posedge clk_sys_in) begin
    cycles   <= cycles + 1;
    low_run  <= opr_n ? 0 : low_run + 1;
    if (press == 0)
      press <= (low_run >= OPR_MIN_LOW_CYC) ? 1 : 0;
    else
      press <= (press <= OPR_ASSERT_CYC || !opr_n) ? press + 1 : 0;
    good_run <= (sup_low || !reset_n_in || press > OPR_ASSERT_CYC) ? 0
                                                                 : good_run + 1;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : cyc
  task automatic chk(input logic act, input logic exp);
    comparisons++;
    if (act !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t output mismatch", $time);
    end
  endtask : chk
  task automatic chk_cnt(input int act, input int exp);
    comparisons++;
    if (act != exp) begin
      error_cnt++;
      $display("[FAIL] %0t count mismatch", $time);
    end
  endtask : chk_cnt
  // Settled values are read mid-cycle, clear of the launching edge
  task automatic chk_rst;
    logic on;
    @(negedge clk_sys_in);
    on = sup_low || good_run < T;
    chk(rst_lo, !on);
    chk(rst_hi, on);
  endtask : chk_rst
  task automatic test_done;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial begin
    cyc(4);
    reset_n_in <= 1'b1;
    cyc(T / 2); chk_rst();
    cyc(T); chk_rst();
    // Long enough for the monitor's low-supply check to engage
    @(posedge clk_sys_in) sup_low <= 1'b1;
    cyc(6); sup_low <= 1'b0;
    cyc(T / 2); chk_rst();
    @(posedge clk_sys_in) sup_low <= 1'b1;
    cyc(2); sup_low <= 1'b0;
    cyc(T / 2); chk_rst();
    cyc(T); chk_rst();
    // Outside logic drives the operator input; a short low is ignored
    @(posedge clk_sys_in) opr_n <= 1'b0;
    cyc(1200); opr_n <= 1'b1;
    cyc(4); chk_rst();
    // A recognised press asserts reset after the delay, though released
    @(posedge clk_sys_in) opr_n <= 1'b0;
    cyc(1300); opr_n <= 1'b1;
    cyc(300); chk_rst();
    cyc(265); chk_rst();
    cyc(T); chk_rst();
    @(posedge clk_sys_in) opr_n <= 1'b0;
    cyc(1900); chk_rst();
    cyc(T); opr_n <= 1'b1;
    cyc(T / 2); chk_rst();
    cyc(T); chk_rst();
    for (int i = 0; i < 24; i++) begin
      nx = 1'($random(seed));
      if (nx && !early) falls++;
      @(posedge clk_sys_in);
      warn  <= 1'($random(seed));
      early <= nx;
      cyc(6); chk_rst();
      chk(warn_flag, !warn);
      chk(early_flag, !early);
    end
    chk_cnt(nmi_cnt, falls);
    test_done();
  end
endmodule : test_supply_supervisor_reset_sequencer
